// File: src/swb_ctrl.sv
// Controller end: AHB-Lite registers, link clock, command spacing, write data
`timescale 1ns/1ps
`default_nettype none
module swb_ctrl (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Link to the memory
    swb_if.ctrl link
);
    // ------------------------------------------------------------
    // Types and state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [swb_pkg::BEATS*swb_pkg::DQ_W-1:0] data;
        logic [swb_pkg::BEATS*swb_pkg::LANES-1:0] mask;
        logic chop;
    } swb_ctrl_ent_t;

    typedef struct packed {
        logic ap_wr;
        logic ap_rd;
        logic [7:0] ap_addr;
        logic [31:0] ctrl;
        logic [15:0] pcmd;
        logic pend;
        logic [3:0][31:0] dat;
        logic [15:0] mask;
        logic refused;
        logic [2:0] cnt;
        logic ck;
        logic cmd_we;
        logic a10;
        logic a12;
        logic [swb_pkg::BANK_W-1:0] bank;
        logic [swb_pkg::COL_W-1:0] col;
        logic [swb_pkg::DQ_W-1:0] dq;
        logic dq_oe;
        logic [swb_pkg::LANES-1:0] dm_n;
        logic dqs;
        logic dqs_oe;
        logic [4:0] gap;
        logic [7:0] rec;
        logic rec_arm;
        logic [swb_pkg::PIPE_W-1:0] pipe;
        swb_ctrl_ent_t [swb_pkg::QD-1:0] q;
        logic [swb_pkg::QA_W-1:0] wp;
        logic [swb_pkg::QA_W-1:0] rp;
        logic act;
        logic [2:0] beat;
        swb_ctrl_ent_t cur;
    } swb_ctrl_st_t;

    swb_ctrl_st_t s;
    swb_ctrl_st_t next_s;
    logic [swb_pkg::WL_W-1:0] wl;
    logic pre2;
    logic cfg_bad;
    logic gap_ok;
    logic full;
    logic busy;

    assign pre2 = s.ctrl[swb_pkg::CTRL_PRE2];
    assign wl = swb_pkg::wl_calc(s.ctrl[swb_pkg::CTRL_AL +: 2], s.ctrl[swb_pkg::CTRL_CL +: 5],
                                 s.ctrl[swb_pkg::CTRL_CWL +: 5]);
    assign cfg_bad = (pre2 && s.ctrl[swb_pkg::CTRL_CWL +: 5] == swb_pkg::CWL_BAN_PRE2)
        || (s.ctrl[swb_pkg::CTRL_DM] && s.ctrl[swb_pkg::CTRL_DBI]);
    // Gap counts rises since the last command; the next command lands one rise later
    // Compared against the limit minus one because the new command is counted at the rise after it is issued
    assign gap_ok = (s.gap >= swb_pkg::CCD_MIN - 5'h01)
        && !(pre2 && s.gap == swb_pkg::CCD_MIN - 5'h01);
    assign full = (s.wp + 3'h1) == s.rp;
    assign busy = s.pend || s.act || (|s.pipe) || (s.wp != s.rp);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        // AHB address phase capture
        next_s.ap_wr = hsel && htrans[1] && hready && hwrite;
        next_s.ap_rd = hsel && htrans[1] && hready && !hwrite;
        next_s.ap_addr = haddr[7:0];
        if (s.ap_wr) begin
            case (s.ap_addr)
                swb_pkg::REG_CTRL: begin
                    next_s.ctrl = hwdata;
                end
                swb_pkg::REG_CMD: begin
                    // Illegal modes are refused here, never sent on the link
                    if (s.pend || cfg_bad) begin
                        next_s.refused = 1'b1;
                    end else begin
                        next_s.pend = 1'b1;
                        next_s.pcmd = hwdata[15:0];
                    end
                end
                swb_pkg::REG_MASK: begin
                    next_s.mask = hwdata[15:0];
                end
                swb_pkg::REG_STAT: begin
                    if (hwdata[swb_pkg::ST_REF]) next_s.refused = 1'b0;
                end
                default: begin
                    if (s.ap_addr >= swb_pkg::REG_DAT0 && s.ap_addr < swb_pkg::REG_MASK) begin
                        next_s.dat[s.ap_addr[3:2] - 2'h2] = hwdata;
                    end
                end
            endcase
        end
        // Link clock divider
        next_s.cnt = (s.cnt == swb_pkg::PH_RISE) ? 3'h0 : s.cnt + 3'h1;
        next_s.ck = next_s.cnt < swb_pkg::CK_HALF;
        if (s.cnt == swb_pkg::PH_RISE) begin
            next_s.pipe = {s.pipe[swb_pkg::PIPE_W-2:0], s.cmd_we};
            next_s.gap = s.cmd_we ? 5'h00 : ((s.gap == swb_pkg::GAP_SAT) ? s.gap : s.gap + 5'h01);
            // Recovery counts from the first rise after the last beat
            next_s.rec = s.rec_arm ? 8'h00 : ((s.rec == 8'hFF) ? s.rec : s.rec + 8'h01);
            next_s.rec_arm = 1'b0;
        end
        // Commands change at the falling edge so the rise samples them stable
        if (s.cnt == swb_pkg::PH_FALL) begin
            next_s.cmd_we = 1'b0;
            if (s.pend && gap_ok && !full) begin
                next_s.cmd_we = 1'b1;
                next_s.pend = 1'b0;
                next_s.bank = s.pcmd[swb_pkg::CMD_BANK +: swb_pkg::BANK_W];
                next_s.col = s.pcmd[swb_pkg::CMD_COL +: swb_pkg::COL_W];
                next_s.a10 = s.pcmd[swb_pkg::CMD_A10];
                next_s.a12 = s.pcmd[swb_pkg::CMD_A12];
                next_s.q[s.wp].data = s.dat;
                next_s.q[s.wp].mask = s.mask;
                next_s.q[s.wp].chop = swb_pkg::is_chop(s.ctrl[swb_pkg::CTRL_BL +: 2],
                                                      s.pcmd[swb_pkg::CMD_A12]);
                next_s.wp = s.wp + 3'h1;
            end
        end
        // Even beats change before a rise, odd beats before a fall
        if (s.cnt == swb_pkg::PH_EVEN) begin
            if (swb_pkg::tap(s.pipe, wl, 6'h01)) begin
                next_s.cur = s.q[s.rp];
                next_s.rp = s.rp + 3'h1;
                next_s.act = 1'b1;
                next_s.beat = 3'h0;
            end else if (!s.act) begin
                next_s.dq_oe = 1'b0;
                next_s.dqs = 1'b0;
                next_s.dqs_oe = swb_pkg::tap(s.pipe, wl, 6'h02) || (pre2 && swb_pkg::tap(s.pipe, wl, 6'h03));
            end
        end
        if (next_s.act && (s.cnt == swb_pkg::PH_EVEN || s.cnt == swb_pkg::PH_ODD)) begin
            next_s.dq = next_s.cur.data[next_s.beat*swb_pkg::DQ_W +: swb_pkg::DQ_W];
            next_s.dm_n = next_s.cur.mask[next_s.beat*swb_pkg::LANES +: swb_pkg::LANES];
            next_s.dq_oe = 1'b1;
            next_s.dqs_oe = 1'b1;
            next_s.dqs = !next_s.beat[0];
            if (next_s.beat == (next_s.cur.chop ? swb_pkg::LAST_BC4 : swb_pkg::LAST_BL8)) begin
                next_s.act = 1'b0;
                next_s.rec_arm = 1'b1;
            end else begin
                next_s.beat = next_s.beat + 3'h1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.ctrl <= swb_pkg::CTRL_RST;
            // Start in the low half so the first link clock pulse is full width
            s.cnt <= swb_pkg::CK_HALF;
            s.gap <= swb_pkg::GAP_SAT;
            s.rec <= 8'hFF;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Bus answers and link outputs
    // ------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_comb begin
        hrdata = 32'h0000_0000;
        if (s.ap_rd) begin
            case (s.ap_addr)
                swb_pkg::REG_CTRL: hrdata = s.ctrl;
                swb_pkg::REG_CMD: hrdata = {16'h0000, s.pcmd};
                swb_pkg::REG_MASK: hrdata = {16'h0000, s.mask};
                swb_pkg::REG_STAT: begin
                    hrdata[swb_pkg::ST_PEND] = s.pend;
                    hrdata[swb_pkg::ST_BUSY] = busy;
                    hrdata[swb_pkg::ST_REF] = s.refused;
                    hrdata[swb_pkg::ST_CRCP] = s.ctrl[swb_pkg::CTRL_CRC] && s.ctrl[swb_pkg::CTRL_DM];
                    hrdata[swb_pkg::ST_REC +: 8] = s.rec;
                end
                default: begin
                    if (s.ap_addr >= swb_pkg::REG_DAT0 && s.ap_addr < swb_pkg::REG_MASK) begin
                        hrdata = s.dat[s.ap_addr[3:2] - 2'h2];
                    end
                end
            endcase
        end
    end

    assign link.ck = s.ck;
    assign link.cmd_we = s.cmd_we;
    assign link.a10 = s.a10;
    assign link.a12 = s.a12;
    assign link.bank = s.bank;
    assign link.col = s.col;
    assign link.dq = s.dq;
    assign link.dq_oe = s.dq_oe;
    assign link.dm_n = s.dm_n;
    assign link.dqs = s.dqs;
    assign link.dqs_oe = s.dqs_oe;
endmodule
`default_nettype wire

// File: src/swb_dev.sv
// Memory end: write command decode, latency, burst capture and masking
`timescale 1ns/1ps
`default_nettype none
module swb_dev (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Link from the controller
    swb_if.dev link,
    // Mode settings
    input wire logic [1:0] bl_mode,
    input wire logic [1:0] al_sel,
    input wire logic [4:0] cl,
    input wire logic [4:0] cwl,
    input wire logic [1:0] org,
    input wire logic dm_en,
    input wire logic dbi_en,
    input wire logic crc_en,
    input wire logic dll_locked,
    // Array write port
    output logic wr_en,
    output logic [swb_pkg::BANK_W-1:0] wr_bank,
    output logic [swb_pkg::COL_W-1:0] wr_col,
    output logic [swb_pkg::DQ_W-1:0] wr_data,
    output logic [swb_pkg::LANES-1:0] wr_be,
    // Bank state
    output logic pre_en,
    output logic [swb_pkg::BANK_W-1:0] pre_bank,
    output logic [(1 << swb_pkg::BANK_W)-1:0] bank_open,
    // Status
    output logic crc_persist,
    output logic crc_nonpersist,
    output logic cfg_conflict,
    output logic cmd_drop
);
    // ------------------------------------------------------------
    // Types and state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [swb_pkg::BANK_W-1:0] bank;
        logic [swb_pkg::COL_W-1:0] col;
        logic ap;
        logic chop;
    } swb_dev_ent_t;

    typedef struct packed {
        logic ck_d;
        logic [swb_pkg::PIPE_W-1:0] pipe;
        swb_dev_ent_t [swb_pkg::QD-1:0] q;
        logic [swb_pkg::QA_W-1:0] wp;
        logic [swb_pkg::QA_W-1:0] rp;
        logic act;
        logic [2:0] beat;
        swb_dev_ent_t cur;
        logic wr_en;
        logic [swb_pkg::BANK_W-1:0] wr_bank;
        logic [swb_pkg::COL_W-1:0] wr_col;
        logic [swb_pkg::DQ_W-1:0] wr_data;
        logic [swb_pkg::LANES-1:0] wr_be;
        logic pre_en;
        logic [swb_pkg::BANK_W-1:0] pre_bank;
        logic [(1 << swb_pkg::BANK_W)-1:0] bank_open;
        logic cmd_drop;
    } swb_dev_st_t;

    localparam int SW = 4 + swb_pkg::BANK_W + swb_pkg::COL_W + swb_pkg::DQ_W + swb_pkg::LANES;

    swb_dev_st_t s;
    swb_dev_st_t next_s;
    logic [SW-1:0] raw;
    logic [SW-1:0] syn;
    logic ck_s;
    logic cmd_s;
    logic a10_s;
    logic a12_s;
    logic [swb_pkg::BANK_W-1:0] bank_s;
    logic [swb_pkg::COL_W-1:0] col_s;
    logic [swb_pkg::DQ_W-1:0] dq_s;
    logic [swb_pkg::LANES-1:0] dm_s;
    logic [swb_pkg::LANES-1:0] lane_on;
    logic [swb_pkg::LANES-1:0] lane_be;
    logic [swb_pkg::WL_W-1:0] wl;
    logic mask_on;
    logic rise;
    logic fall;
    logic full;

    // ------------------------------------------------------------
    // Link input synchronisation
    // ------------------------------------------------------------
    // Data and clock share one delay so they stay aligned
    assign raw = {link.ck, link.cmd_we, link.a10, link.a12, link.bank, link.col, link.dq, link.dm_n};

    swb_sync #(.W(SW)) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .din(raw),
        .dout(syn)
    );

    assign {ck_s, cmd_s, a10_s, a12_s, bank_s, col_s, dq_s, dm_s} = syn;
    assign rise = ck_s && !s.ck_d;
    assign fall = !ck_s && s.ck_d;
    assign full = (s.wp + 3'h1) == s.rp;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    assign wl = swb_pkg::wl_calc(al_sel, cl, cwl);
    assign cfg_conflict = dm_en && dbi_en;
    // Masking is switched off rather than guessed when both are set
    assign mask_on = dm_en && !dbi_en && (org != swb_pkg::ORG_X4);
    assign crc_persist = crc_en && dm_en;
    assign crc_nonpersist = crc_en && !dm_en;

    for (genvar i = 0; i < swb_pkg::LANES; i++) begin : g_lane
        assign lane_on[i] = (i == 0) || (org == swb_pkg::ORG_X16);
        assign lane_be[i] = lane_on[i] && (!mask_on || dm_s[i]);
    end

    // ------------------------------------------------------------
    // Command pipe and burst capture
    // ------------------------------------------------------------
    always_comb begin
        logic cap;
        cap = 1'b0;
        next_s = s;
        next_s.ck_d = ck_s;
        next_s.wr_en = 1'b0;
        next_s.pre_en = 1'b0;
        next_s.cmd_drop = 1'b0;
        if (rise) begin
            next_s.pipe = {s.pipe[swb_pkg::PIPE_W-2:0], 1'b0};
            if (cmd_s) begin
                // Without a locked DLL the data timing cannot be trusted
                if (!dll_locked || full) begin
                    next_s.cmd_drop = 1'b1;
                end else begin
                    next_s.pipe[0] = 1'b1;
                    next_s.q[s.wp].bank = bank_s;
                    next_s.q[s.wp].col = col_s;
                    next_s.q[s.wp].ap = a10_s;
                    next_s.q[s.wp].chop = swb_pkg::is_chop(bl_mode, a12_s);
                    next_s.wp = s.wp + 3'h1;
                    next_s.bank_open[bank_s] = 1'b1;
                end
            end
            // First beat lands on the rising edge that ends the latency
            if (swb_pkg::tap(s.pipe, wl, 6'h01)) begin
                next_s.cur = s.q[s.rp];
                next_s.rp = s.rp + 3'h1;
                next_s.beat = 3'h0;
                cap = 1'b1;
            end else begin
                cap = s.act;
            end
        end else if (fall) begin
            cap = s.act;
        end
        if (cap) begin
            next_s.wr_en = 1'b1;
            next_s.wr_bank = next_s.cur.bank;
            next_s.wr_col = {next_s.cur.col[swb_pkg::COL_W-1:3], next_s.beat};
            next_s.wr_data = dq_s;
            next_s.wr_be = lane_be;
            if (next_s.beat == (next_s.cur.chop ? swb_pkg::LAST_BC4 : swb_pkg::LAST_BL8)) begin
                next_s.act = 1'b0;
                if (next_s.cur.ap) begin
                    next_s.pre_en = 1'b1;
                    next_s.pre_bank = next_s.cur.bank;
                    next_s.bank_open[next_s.cur.bank] = 1'b0;
                end
            end else begin
                next_s.act = 1'b1;
                next_s.beat = next_s.beat + 3'h1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign wr_en = s.wr_en;
    assign wr_bank = s.wr_bank;
    assign wr_col = s.wr_col;
    assign wr_data = s.wr_data;
    assign wr_be = s.wr_be;
    assign pre_en = s.pre_en;
    assign pre_bank = s.pre_bank;
    assign bank_open = s.bank_open;
    assign cmd_drop = s.cmd_drop;
endmodule
`default_nettype wire

// File: src/swb_if.sv
// Command, address and write data link between controller and memory
`timescale 1ns/1ps
`default_nettype none
interface swb_if;
    logic ck;
    logic cmd_we;
    logic a10;
    logic a12;
    logic [swb_pkg::BANK_W-1:0] bank;
    logic [swb_pkg::COL_W-1:0] col;
    logic [swb_pkg::DQ_W-1:0] dq;
    logic dq_oe;
    logic [swb_pkg::LANES-1:0] dm_n;
    logic dqs;
    logic dqs_oe;
    modport ctrl (output ck, cmd_we, a10, a12, bank, col, dq, dq_oe, dm_n, dqs, dqs_oe);
    modport dev (input ck, cmd_we, a10, a12, bank, col, dq, dq_oe, dm_n, dqs, dqs_oe);
endinterface
`default_nettype wire

// File: src/swb_pkg.sv
// Shared constants, field layouts and helpers for the write burst path
package swb_pkg;
    // --------------------------------------------------------------
    // Widths and depths
    // --------------------------------------------------------------
    localparam int DQ_W = 16;
    localparam int LANES = 2;
    localparam int BANK_W = 4;
    localparam int COL_W = 10;
    localparam int WL_W = 6;
    localparam int PIPE_W = 64;
    localparam int QD = 8;
    localparam int QA_W = 3;
    localparam int BEATS = 8;
    localparam logic [2:0] LAST_BL8 = 3'h7;
    localparam logic [2:0] LAST_BC4 = 3'h3;
    // --------------------------------------------------------------
    // Mode encodings
    // --------------------------------------------------------------
    localparam logic [1:0] BL_FIX8 = 2'h0;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam logic [1:0] BL_FIX4 = 2'h2;
    localparam logic [1:0] AL_CLM1 = 2'h1;
    localparam logic [1:0] AL_CLM2 = 2'h2;
    localparam logic [1:0] ORG_X4 = 2'h0;
    localparam logic [1:0] ORG_X8 = 2'h1;
    localparam logic [1:0] ORG_X16 = 2'h2;
    localparam logic [4:0] CWL_BAN_PRE2 = 5'h09;
    localparam logic [4:0] CCD_MIN = 5'h05;
    localparam logic [4:0] GAP_SAT = 5'h1F;
    // --------------------------------------------------------------
    // Link clock made by the controller
    // --------------------------------------------------------------
    localparam int HCLK_NS = 50;
    localparam int CK_NS = 400;
    localparam int CK_DIV = CK_NS / HCLK_NS;
    localparam logic [2:0] PH_RISE = 3'(CK_DIV - 1);
    localparam logic [2:0] PH_FALL = 3'(CK_DIV / 2 - 1);
    localparam logic [2:0] PH_ODD = 3'h1;
    localparam logic [2:0] PH_EVEN = 3'h5;
    localparam logic [2:0] CK_HALF = 3'(CK_DIV / 2);
    // --------------------------------------------------------------
    // Controller register map and fields
    // --------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_DAT0 = 8'h08;
    localparam logic [7:0] REG_MASK = 8'h18;
    localparam logic [7:0] REG_STAT = 8'h1C;
    localparam int CTRL_BL = 0;
    localparam int CTRL_PRE2 = 2;
    localparam int CTRL_DM = 3;
    localparam int CTRL_DBI = 4;
    localparam int CTRL_CRC = 5;
    localparam int CTRL_AL = 6;
    localparam int CTRL_CWL = 8;
    localparam int CTRL_CL = 16;
    localparam logic [31:0] CTRL_RST = 32'h000B_0900;
    localparam int CMD_BANK = 0;
    localparam int CMD_COL = 4;
    localparam int CMD_A10 = 14;
    localparam int CMD_A12 = 15;
    localparam int ST_PEND = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_REF = 2;
    localparam int ST_CRCP = 3;
    localparam int ST_REC = 8;

    function automatic logic is_chop(input logic [1:0] bl, input logic a12);
        return (bl == BL_FIX4) || ((bl == BL_OTF) && !a12);
    endfunction

    function automatic logic [WL_W-1:0] wl_calc(input logic [1:0] al_sel, input logic [4:0] cl,
                                                input logic [4:0] cwl);
        logic [WL_W-1:0] al;
        al = '0;
        if (al_sel == AL_CLM1) al = {1'b0, cl} - 6'h01;
        if (al_sel == AL_CLM2) al = {1'b0, cl} - 6'h02;
        return al + {1'b0, cwl};
    endfunction

    function automatic logic tap(input logic [PIPE_W-1:0] p, input logic [WL_W-1:0] wl,
                                 input logic [WL_W-1:0] back);
        return (wl >= back) ? p[wl - back] : 1'b0;
    endfunction
endpackage

// File: src/swb_sync.sv
// Two flip-flop synchroniser for a vector of link inputs
`timescale 1ns/1ps
`default_nettype none
module swb_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Vectors
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } swb_sync_st_t;
    swb_sync_st_t s;
    swb_sync_st_t next_s;

    // Meta stage feeds the second stage only
    always_comb begin
        next_s.meta = din;
        next_s.q = s.meta;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign dout = s.q;
endmodule
`default_nettype wire

// File: testbench/sdram_write_burst_path_tb_top.sv
// Testbench joining controller and memory ends over the link
`timescale 1ns/1ps
`default_nettype none
module sdram_write_burst_path_tb_top;
    logic hclk = '0, hresetn = '0, hsel = '0, hwrite = '0, dm_en = '0, dbi_en = '0, crc_en = '0;
    logic dll_locked = 1'h1, hreadyout, wr_en, pre_en, crc_persist, crc_nonpersist, cfg_conflict;
    logic [1:0] htrans = '0, bl_mode = '0, al_sel = '0, org = 2'h2, wr_be, be1;
    logic [4:0] cl = '0, cwl = '0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
    logic [15:0] wr_data, d0, bank_open;
    logic [3:0] pre_bank, pb;
    int n_fail = 0, check_count = 0, beats, nck, c0, fwl, nl;
    realtime t0, gapt;
    always #25 hclk = ~hclk;
    swb_if sif();
    swb_ctrl u_swb_ctrl (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .link(sif.ctrl));
    swb_dev u_swb_dev (.hclk, .hresetn, .link(sif.dev), .bl_mode, .al_sel, .cl, .cwl, .org, .dm_en, .dbi_en,
        .crc_en, .dll_locked, .wr_en, .wr_bank(), .wr_col(), .wr_data, .wr_be, .pre_en, .pre_bank, .bank_open,
        .crc_persist, .crc_nonpersist, .cfg_conflict, .cmd_drop());
    swb_asserts u_swb_asserts (.hclk, .hresetn, .ck(sif.ck), .cmd_we(sif.cmd_we), .a10(sif.a10), .a12(sif.a12),
        .bank(sif.bank), .col(sif.col), .dq(sif.dq), .dq_oe(sif.dq_oe), .dm_n(sif.dm_n), .dqs(sif.dqs),
        .dqs_oe(sif.dqs_oe));
    always @(posedge sif.ck) nck++;
    always @(posedge sif.cmd_we) begin
        c0 = nck;
        gapt = $realtime - t0;
        t0 = $realtime;
    end
    always @(posedge hclk) begin
        if (wr_en && beats == 0) fwl = nck - c0;
        if (wr_en && beats == 0) d0 = wr_data;
        if (wr_en && beats == 1) be1 = wr_be;
        if (wr_en) beats++;
        if (wr_en) nl = nck;
        if (pre_en) pb = pre_bank;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        q = hrdata;
    endtask
    // Memory mode pins except org and dll_locked follow the controller setting
    task automatic cfg(input logic [31:0] c);
        bl_mode <= c[1:0];
        dm_en <= c[3];
        dbi_en <= c[4];
        crc_en <= c[5];
        al_sel <= c[7:6];
        cwl <= c[12:8];
        cl <= c[20:16];
        bus(1'h1, swb_pkg::REG_CTRL, c);
        beats = 0;
    endtask
    task automatic go(input logic [31:0] c, input logic [15:0] cmd, input int nb);
        cfg(c);
        bus(1'h1, swb_pkg::REG_CMD, {16'h0, cmd});
        repeat (600) @(posedge hclk);
        chk(beats, nb);
    endtask
    // Second command is queued as soon as the first leaves
    task automatic pair(input logic [31:0] c, input realtime ns);
        cfg(c);
        bus(1'h1, swb_pkg::REG_CMD, 32'h8001);
        do bus(1'h0, swb_pkg::REG_STAT, '0); while (q[0] !== 1'h0);
        bus(1'h1, swb_pkg::REG_CMD, 32'h8002);
        repeat (600) @(posedge hclk);
        chk(gapt, ns);
    endtask
    task automatic end_of_test();
        if (n_fail == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        bus(1'h0, swb_pkg::REG_CTRL, '0);
        chk(q, swb_pkg::CTRL_RST);
        bus(1'h1, swb_pkg::REG_DAT0, 32'h5A5A_1234);
        bus(1'h1, swb_pkg::REG_MASK, 32'hFFFF_FFFB);
        go(32'h000B_0908, 16'h0103, 8);
        chk(d0, 16'h1234);
        chk(be1, 2'h2);
        chk(fwl, 10);
        chk(bank_open[3], 1'h1);
        bus(1'h0, swb_pkg::REG_STAT, '0);
        chk(q[15:8], nck - nl - 1);
        go(32'h000B_0921, 16'h4005, 4);
        chk(pb, 4'h5);
        chk(bank_open[5], 1'h0);
        chk(crc_nonpersist, 1'h1);
        go(32'h000B_0901, 16'h8006, 8);
        go(32'h000B_0902, 16'h8007, 4);
        go(32'h000B_0968, 16'h0008, 8);
        chk(fwl, 20);
        chk(crc_persist, 1'h1);
        bus(1'h0, swb_pkg::REG_STAT, '0);
        chk(q[3], 1'h1);
        go(32'h000B_0918, 16'h0009, 0);
        chk(cfg_conflict, 1'h1);
        bus(1'h0, swb_pkg::REG_STAT, '0);
        chk(q[2], 1'h1);
        bus(1'h1, swb_pkg::REG_STAT, 32'h4);
        go(32'h000B_0904, 16'h000A, 0);
        pair(32'h000B_0900, 2000);
        pair(32'h000B_0A04, 2400);
        org <= 2'h0;
        go(32'h000B_0908, 16'h000B, 8);
        chk(be1, 2'h1);
        dll_locked <= 1'h0;
        go(32'h000B_0900, 16'h000C, 0);
        end_of_test();
    end
    initial begin
        #2000000;
        n_fail++;
        end_of_test();
    end
endmodule
`default_nettype wire

// File: testbench/swb_asserts.sv
// Link checks between the controller and memory ends
`timescale 1ns/1ps
`default_nettype none
module swb_asserts (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Link
    input wire logic ck,
    input wire logic cmd_we,
    input wire logic a10,
    input wire logic a12,
    input wire logic [swb_pkg::BANK_W-1:0] bank,
    input wire logic [swb_pkg::COL_W-1:0] col,
    input wire logic [swb_pkg::DQ_W-1:0] dq,
    input wire logic dq_oe,
    input wire logic [swb_pkg::LANES-1:0] dm_n,
    input wire logic dqs,
    input wire logic dqs_oe
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Saturating hclk count since the last command start
    logic [5:0] gap;
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn) gap <= 6'h3F;
        else gap <= $rose(cmd_we) ? 6'h00 : gap + {5'h00, gap != 6'h3F};
    property p_ck_hi; $rose(ck) |-> ck [*4] ##1 !ck; endproperty
    a_ck_hi: assert property (p_ck_hi) else $error("ck high time");
    property p_ck_lo; $fell(ck) |-> !ck [*4] ##1 ck; endproperty
    a_ck_lo: assert property (p_ck_lo) else $error("ck low time");
    property p_cmd_len; $rose(cmd_we) |-> cmd_we [*8] ##1 !cmd_we; endproperty
    a_cmd_len: assert property (p_cmd_len) else $error("command length");
    property p_gap; $rose(cmd_we) |-> gap >= 6'h27; endproperty
    a_gap: assert property (p_gap) else $error("command spacing");
    property p_addr; cmd_we && $past(cmd_we) |-> $stable({a10, a12, bank, col}); endproperty
    a_addr: assert property (p_addr) else $error("address moved");
    property p_pre; $rose(dqs_oe) |-> !dqs [*4]; endproperty
    a_pre: assert property (p_pre) else $error("preamble");
    property p_dqs; dqs_oe && $changed(dqs) |=> $stable(dqs) [*3]; endproperty
    a_dqs: assert property (p_dqs) else $error("strobe rate");
    property p_dq; dq_oe && $past(dq_oe) && $changed({dq, dm_n}) |=> $stable({dq, dm_n}) [*3]; endproperty
    a_dq: assert property (p_dq) else $error("data beat length");
    c_chop: cover property ($rose(cmd_we) && !a12);
    c_wra: cover property ($rose(cmd_we) && a10);
    c_pre: cover property ($rose(dqs_oe));
endmodule
`default_nettype wire
